// *** sswx_core.sv ***
/*
  sswx_core: execution datapath for subtract, subtract with borrow,
  subtract from literal, nibble exchange, direction load and xor, driven
  from an AXI4-Lite register slave. A write to the command register runs
  one operation in the following cycle.
  Assumes a single 10 MHz clock, synchronous active-low reset and an
  AXI4-Lite master that keeps to the channel handshakes.

  // Function
  // (RULE_01) file minus accumulator, to accumulator if dest 0, else file
  // (RULE_02) borrow form also subtracts inverted carry; updates C, DC, Z
  // (RULE_03) borrow-form result goes to accumulator on dest 0, file on 1
  // (RULE_04) literal minus accumulator always lands in accumulator; C, DC, Z
  // (RULE_05) nibble exchange of file value; dest selects target; no flags
  // (RULE_06) direction load copies accumulator: 5 to A, 6 to B, 7 to C
  // (RULE_07) direction load accepts operands 5 to 7 only; flags untouched
  // (RULE_08) xor with immediate into accumulator; only zero flag changes
  // (RULE_09) xor with file; dest selects target; only zero flag changes
  // (RULE_10) carry clear when subtrahend exceeds minuend; same on low nibble
  // (RULE_11) zero flag set exactly when the 8-bit result is zero
*/
`timescale 1ns/1ps
module sswx_core
  import sswx_pkg::*;
(
  input wire logic aclk,                  // 10 MHz clock
  input wire logic aresetn,               // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid,         // write address valid
  output logic s_axi_awready,             // write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb,     // byte lanes
  input wire logic s_axi_wvalid,          // write data valid
  output logic s_axi_wready,              // write data ready
  output logic [1:0] s_axi_bresp,         // write response
  output logic s_axi_bvalid,              // write response valid
  input wire logic s_axi_bready,          // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid,         // read address valid
  output logic s_axi_arready,             // read address ready
  output logic [DATA_W-1:0] s_axi_rdata,  // read data
  output logic [1:0] s_axi_rresp,         // read response
  output logic s_axi_rvalid,              // read data valid
  input wire logic s_axi_rready,          // read data ready
  output logic [7:0] port_a_direction,    // port A direction
  output logic [7:0] port_b_direction,    // port B direction
  output logic [7:0] port_c_direction     // port C direction
);

  // address is one of the mapped registers or the file window
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[FILE_WIN_LSB+:3] == FILE_WIN_TAG) ||
              (a == OFF_CMD) || (a == OFF_ACC) || (a == OFF_STAT) ||
              (a == OFF_DIR_A) || (a == OFF_DIR_B) || (a == OFF_DIR_C);
  endfunction

  // file index carried in a window address
  function automatic logic [6:0] file_idx(input logic [ADDR_W-1:0] a);
    file_idx = a[FILE_IDX_LSB+:7];
  endfunction

  // byte-lane merge for the command word
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8+:8] = strb[i] ? data[i*8+:8] : old[i*8+:8];
    end
  endfunction

  // write channel state
  logic aw_hold_ff, nxt_aw_hold;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic w_hold_ff, nxt_w_hold;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic do_wr;

  // read channel state
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // core state
  sswx_state_t state_ff, nxt_state;
  logic [31:0] cmd_ff, nxt_cmd;
  logic [7:0] acc_ff, nxt_acc;
  logic c_ff, nxt_c;
  logic dc_ff, nxt_dc;
  logic z_ff, nxt_z;
  logic err_ff, nxt_err;
  logic [7:0] dir_ff [0:2];
  logic [7:0] nxt_dir [0:2];

  // file memory ports and alu wiring
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] fval;
  logic [7:0] bus_fval;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_z, alu_upd_cdc, alu_upd_z;
  sswx_op_t cur_op;
  logic cur_dest;
  logic [6:0] cur_faddr;
  logic [7:0] cur_lit;
  logic [1:0] dir_sel;

  assign cur_op = sswx_op_t'(cmd_ff[CMD_OP_LSB+:3]);
  assign cur_dest = cmd_ff[CMD_DEST_BIT];
  assign cur_faddr = cmd_ff[CMD_FADDR_LSB+:7];
  assign cur_lit = cmd_ff[CMD_LIT_LSB+:8];
  // operand 5..7 maps to direction index 0..2
  assign dir_sel = 2'(cur_faddr - DIR_OPND_A); // see (RULE_06)

  sswx_file_mem u_mem
  (
    .aclk(aclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(cur_faddr),
    .rdata_a(fval),
    .raddr_b(file_idx(s_axi_araddr)),
    .rdata_b(bus_fval)
  );

  sswx_alu u_alu
  (
    .op(cur_op),
    .acc(acc_ff),
    .fval(fval),
    .lit(cur_lit),
    .c_in(c_ff),
    .result(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .upd_cdc(alu_upd_cdc),
    .upd_z(alu_upd_z)
  );

  // write channel: address and data taken in either order; writes wait
  // while an operation runs so bus and core never update one register
  always_comb
  begin
    do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff && (state_ff == ST_IDLE);
    nxt_aw_hold = aw_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && awready_ff)
    begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff)
    begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr)
    begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = addr_ok(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_awready = !nxt_aw_hold;
    nxt_wready = !nxt_w_hold;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      awaddr_ff <= nxt_awaddr;
      w_hold_ff <= nxt_w_hold;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // read channel: one read at a time, data one cycle after the address
  always_comb
  begin
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
    if (s_axi_arvalid && arready_ff)
    begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      nxt_rdata = 32'h0000_0000;
      if (s_axi_araddr[FILE_WIN_LSB+:3] == FILE_WIN_TAG)
        nxt_rdata[7:0] = bus_fval;
      else if (s_axi_araddr == OFF_CMD)
        nxt_rdata = cmd_ff;
      else if (s_axi_araddr == OFF_ACC)
        nxt_rdata[7:0] = acc_ff;
      else if (s_axi_araddr == OFF_STAT)
      begin
        nxt_rdata[ST_C_BIT] = c_ff;
        nxt_rdata[ST_DC_BIT] = dc_ff;
        nxt_rdata[ST_Z_BIT] = z_ff;
        nxt_rdata[ST_ERR_BIT] = err_ff;
        nxt_rdata[ST_BUSY_BIT] = (state_ff == ST_EXEC);
      end
      else if (s_axi_araddr == OFF_DIR_A)
        nxt_rdata[7:0] = dir_ff[0];
      else if (s_axi_araddr == OFF_DIR_B)
        nxt_rdata[7:0] = dir_ff[1];
      else if (s_axi_araddr == OFF_DIR_C)
        nxt_rdata[7:0] = dir_ff[2];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // core: bus writes in idle, one operation per command in exec
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_acc = acc_ff;
    nxt_c = c_ff;
    nxt_dc = dc_ff;
    nxt_z = z_ff;
    nxt_err = err_ff;
    for (int i = 0; i < 3; i++)
    begin
      nxt_dir[i] = dir_ff[i];
    end
    mem_we = 1'b0;
    mem_waddr = cur_faddr;
    mem_wdata = alu_res;
    case (state_ff)
      ST_IDLE:
      begin
        if (do_wr && wstrb_ff[0])
        begin
          if (awaddr_ff[FILE_WIN_LSB+:3] == FILE_WIN_TAG)
          begin
            mem_we = 1'b1;
            mem_waddr = file_idx(awaddr_ff);
            mem_wdata = wdata_ff[7:0];
          end
          else if (awaddr_ff == OFF_ACC)
            nxt_acc = wdata_ff[7:0];
          else if (awaddr_ff == OFF_STAT)
          begin
            // software may preset flags, e.g. carry before a borrow chain
            nxt_c = wdata_ff[ST_C_BIT];
            nxt_dc = wdata_ff[ST_DC_BIT];
            nxt_z = wdata_ff[ST_Z_BIT];
          end
        end
        if (do_wr && (awaddr_ff == OFF_CMD) && (wstrb_ff != 4'h0))
        begin
          nxt_cmd = merge(cmd_ff, wdata_ff, wstrb_ff);
          nxt_err = 1'b0;
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        nxt_state = ST_IDLE;
        if (alu_upd_cdc)
        begin
          nxt_c = alu_c; // see (RULE_02) see (RULE_04) see (RULE_10)
          nxt_dc = alu_dc; // see (RULE_10)
        end
        if (alu_upd_z)
          nxt_z = alu_z; // see (RULE_08) see (RULE_09) see (RULE_11)
        case (cur_op)
          OP_SUB_FILE, OP_SUB_BORROW, OP_SWAP, OP_XOR_FILE:
          begin
            // dest 1 writes the file, dest 0 the accumulator
            if (cur_dest)
              mem_we = 1'b1; // see (RULE_01) see (RULE_03) see (RULE_05)
            else
              nxt_acc = alu_res; // see (RULE_03) see (RULE_09)
          end
          OP_SUB_LIT, OP_XOR_LIT:
            nxt_acc = alu_res; // see (RULE_04) see (RULE_08)
          OP_DIR_LOAD:
          begin
            // out-of-range operand loads nothing and raises the error bit
            if ((cur_faddr >= DIR_OPND_A) && (cur_faddr <= DIR_OPND_C))
              nxt_dir[dir_sel] = acc_ff; // see (RULE_06) see (RULE_07)
            else
              nxt_err = 1'b1; // see (RULE_07)
          end
          default:
            nxt_err = 1'b1;
        endcase
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      cmd_ff <= 32'h0000_0000;
      acc_ff <= ACC_RST;
      c_ff <= 1'b0;
      dc_ff <= 1'b0;
      z_ff <= 1'b0;
      err_ff <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        dir_ff[i] <= DIR_RST;
      end
    end
    else
    begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      acc_ff <= nxt_acc;
      c_ff <= nxt_c;
      dc_ff <= nxt_dc;
      z_ff <= nxt_z;
      err_ff <= nxt_err;
      for (int i = 0; i < 3; i++)
      begin
        dir_ff[i] <= nxt_dir[i];
      end
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign port_a_direction = dir_ff[0];
  assign port_b_direction = dir_ff[1];
  assign port_c_direction = dir_ff[2];

endmodule

// *** sswx_pkg.sv ***
/*
  sswx_pkg: shared constants and types for the subtract, swap and xor
  execution datapath: opcodes, register offsets, field positions, resets.
  Assumes a 32-bit AXI4-Lite register bus with 12 address bits decoded.
*/
package sswx_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_ACC = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_DIR_A = 12'h00C;
  localparam logic [11:0] OFF_DIR_B = 12'h010;
  localparam logic [11:0] OFF_DIR_C = 12'h014;
  // file register window, one word per file address
  localparam logic [2:0] FILE_WIN_TAG = 3'h1;
  localparam int FILE_WIN_LSB = 9;
  localparam int FILE_IDX_LSB = 2;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_FADDR_LSB = 8;
  localparam int CMD_LIT_LSB = 16;

  // status word bits
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_BUSY_BIT = 4;

  // direction-load operand codes
  localparam logic [6:0] DIR_OPND_A = 7'h05;
  localparam logic [6:0] DIR_OPND_C = 7'h07;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    OP_SUB_FILE = 3'h0,   // subtract_acc_from_file_op
    OP_SUB_BORROW = 3'h1, // subtract_with_borrow_op
    OP_SUB_LIT = 3'h2,    // subtract_from_literal_op
    OP_SWAP = 3'h3,       // nibble_exchange_op
    OP_DIR_LOAD = 3'h4,   // load_direction_op
    OP_XOR_LIT = 3'h5,    // xor_immediate_op
    OP_XOR_FILE = 3'h6    // xor_file_op
  } sswx_op_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } sswx_state_t;

endpackage

// *** sswx_file_mem.sv ***
/*
  sswx_file_mem: 128 x 8 file register array, one synchronous write port
  and two combinational read ports (execution and bus read).
  Assumes a single clock; write and read on the same address see old data.
*/
`timescale 1ns/1ps
module sswx_file_mem
(
  input wire logic aclk,          // system clock
  input wire logic we,            // write enable
  input wire logic [6:0] waddr,   // write address
  input wire logic [7:0] wdata,   // write data
  input wire logic [6:0] raddr_a, // execution read address
  output logic [7:0] rdata_a,     // execution read data
  input wire logic [6:0] raddr_b, // bus read address
  output logic [7:0] rdata_b      // bus read data
);

  logic [7:0] mem [0:127];

  // no reset: file contents are undefined until written, as in a core
  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule

// *** sswx_alu.sv ***
/*
  sswx_alu: combinational result and flag logic for one operation.
  Assumes operands are stable for the cycle in which the result is used.
*/
`timescale 1ns/1ps
module sswx_alu
  import sswx_pkg::*;
(
  input wire sswx_op_t op,      // operation
  input wire logic [7:0] acc,   // accumulator
  input wire logic [7:0] fval,  // addressed file register
  input wire logic [7:0] lit,   // immediate
  input wire logic c_in,        // current carry
  output logic [7:0] result,    // operation result
  output logic c_out,           // new carry
  output logic dc_out,          // new half_borrow_flag
  output logic z_out,           // new null-result flag
  output logic upd_cdc,         // carry and half borrow change
  output logic upd_z            // null-result flag changes
);

  logic [8:0] diff;
  logic [4:0] hdiff;
  logic [7:0] minu;
  logic borrow;

  // subtract path shared by the three subtract forms
  always_comb
  begin
    minu = (op == OP_SUB_LIT) ? lit : fval;
    borrow = (op == OP_SUB_BORROW) ? ~c_in : 1'b0; // see (RULE_02)
    diff = {1'b0, minu} - {1'b0, acc} - {8'h00, borrow};
    hdiff = {1'b0, minu[3:0]} - {1'b0, acc[3:0]} - {4'h0, borrow};
    result = diff[7:0];
    upd_cdc = 1'b0;
    upd_z = 1'b0;
    case (op)
      OP_SUB_FILE, OP_SUB_BORROW, OP_SUB_LIT:
      begin
        result = diff[7:0]; // see (RULE_01) see (RULE_04)
        upd_cdc = 1'b1;
        upd_z = 1'b1;
      end
      OP_SWAP:
        result = {fval[3:0], fval[7:4]}; // see (RULE_05)
      OP_DIR_LOAD:
        result = acc; // see (RULE_07)
      OP_XOR_LIT:
      begin
        result = acc ^ lit; // see (RULE_08)
        upd_z = 1'b1;
      end
      OP_XOR_FILE:
      begin
        result = acc ^ fval; // see (RULE_09)
        upd_z = 1'b1;
      end
      default:
        result = acc;
    endcase
    // no borrow out of bit 7 or bit 3 means carry set
    c_out = ~diff[8]; // see (RULE_10)
    dc_out = ~hdiff[4]; // see (RULE_10)
    z_out = (result == 8'h00); // see (RULE_11)
  end

endmodule

// *** sswx_core_sva.sv ***
/*
  sswx_core_sva: bus handshake and direction-register checks on sswx_core.
  Assumes it is bound to the core and sees only the core's ports.
*/
`timescale 1ns/1ps
module sswx_core_sva
  import sswx_pkg::*;
(
  input wire logic aclk,                  // clock
  input wire logic aresetn,               // sync reset, active low
  input wire logic s_axi_awvalid,         // write address valid
  input wire logic s_axi_awready,         // write address ready
  input wire logic s_axi_wvalid,          // write data valid
  input wire logic s_axi_wready,          // write data ready
  input wire logic s_axi_bvalid,          // write response valid
  input wire logic s_axi_bready,          // write response ready
  input wire logic [11:0] s_axi_araddr,   // read address
  input wire logic s_axi_arvalid,         // read address valid
  input wire logic s_axi_arready,         // read address ready
  input wire logic [31:0] s_axi_rdata,    // read data
  input wire logic [1:0] s_axi_rresp,     // read response
  input wire logic s_axi_rvalid,          // read data valid
  input wire logic s_axi_rready,          // read data ready
  input wire logic [7:0] port_a_direction, // port A direction
  input wire logic [7:0] port_b_direction, // port B direction
  input wire logic [7:0] port_c_direction  // port C direction
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // both halves of a write taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // the response is seen two cycles after the take: one to hold the request, one to accept it
  a_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_wr_ready_low: assert property
    (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready not dropped after take");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rd_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not returned next cycle");
  a_rd_release: assert property
    (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_unmapped_rd: assert property
    (rd_taken and s_axi_araddr == 12'h018 |=>
     s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // directions move only in the cycle after a command write completes
  a_dir_cause: assert property (
    $changed(port_a_direction) || $changed(port_b_direction) ||
    $changed(port_c_direction) |-> $past(s_axi_bvalid))
    else $error("direction changed without a command");
  a_dir_onehot: assert property ($onehot0({$changed(port_a_direction),
    $changed(port_b_direction), $changed(port_c_direction)}))
    else $error("more than one direction changed");
endmodule

// *** sswx_core_bench.sv ***
/*
  sswx_core_bench: register-level tests of sswx_core over AXI4-Lite.
  Assumes the core is the only slave and the bench is the only master.
*/
`timescale 1ns/1ps
module sswx_core_bench;
  import sswx_pkg::*;
  localparam logic [11:0] FILE_A = 12'h3FC; // file register 127
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  logic [7:0] exp_dir [3];
  int error_cnt, total_checks;

  sswx_core i_sswx_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_a_direction, .port_b_direction,
    .port_c_direction);

  // 100 ns period
  initial
  begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic done;
    int n;
    done = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'h0;
        done = 1'h1;
      end
    end
    chk("wr_done", {31'h0, done}, 32'h1);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] ed, input logic [1:0] er);
    logic done;
    int n;
    done = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        chk(nm, s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'h0;
        done = 1'h1;
      end
    end
    chk("rd_done", {31'h0, done}, 32'h1);
  endtask

  // preset operands and flags, run one op, compare acc, file and status
  task automatic run_op(input sswx_op_t op, input logic d,
                        input logic [7:0] k, a, fv, input logic ci);
    logic [8:0] df;
    logic [4:0] lo;
    logic [7:0] m, res, ea, ef;
    logic b, c, dc, z;
    m = (op == OP_SUB_LIT) ? k : fv;
    b = (op == OP_SUB_BORROW) ? !ci : 1'h0;
    df = {1'h0, m} - {1'h0, a} - {8'h0, b};
    lo = {1'h0, m[3:0]} - {1'h0, a[3:0]} - {4'h0, b};
    {z, dc, c} = {2'h3, ci};
    case (op)
      OP_SUB_FILE, OP_SUB_BORROW, OP_SUB_LIT:
      begin
        res = df[7:0];
        c = !df[8];
        dc = !lo[4];
        z = (res == 8'h0);
      end
      OP_SWAP: res = {fv[3:0], fv[7:4]};
      default:
      begin
        res = a ^ ((op == OP_XOR_LIT) ? k : fv);
        z = (res == 8'h0);
      end
    endcase
    ea = a;
    ef = fv;
    if (op == OP_SUB_LIT || op == OP_XOR_LIT || !d) ea = res;
    else ef = res;
    wr(FILE_A, {24'h0, fv}, RESP_OKAY);
    wr(OFF_ACC, {24'h0, a}, RESP_OKAY);
    wr(OFF_STAT, {29'h0, 2'h3, ci}, RESP_OKAY);
    wr(OFF_CMD, {8'h0, k, 1'h0, 7'h7F, 4'h0, d, op}, RESP_OKAY);
    rd_chk("acc", OFF_ACC, {24'h0, ea}, RESP_OKAY);
    rd_chk("file", FILE_A, {24'h0, ef}, RESP_OKAY);
    rd_chk("stat", OFF_STAT, {29'h0, z, dc, c}, RESP_OKAY);
  endtask

  // direction load; bad operands must set err and load nothing
  task automatic run_dir(input logic [6:0] opnd, input logic [7:0] a);
    logic err;
    err = (opnd < 7'h05 || opnd > 7'h07);
    wr(OFF_ACC, {24'h0, a}, RESP_OKAY);
    wr(OFF_STAT, 32'h5, RESP_OKAY);
    wr(OFF_CMD, {17'h0, opnd, 5'h0, OP_DIR_LOAD}, RESP_OKAY);
    if (!err) exp_dir[opnd - 7'h05] = a;
    rd_chk("dir_stat", OFF_STAT, {28'h0, err, 3'h5}, RESP_OKAY);
    chk("dir_a", {24'h0, port_a_direction}, {24'h0, exp_dir[0]});
    chk("dir_b", {24'h0, port_b_direction}, {24'h0, exp_dir[1]});
    chk("dir_c", {24'h0, port_c_direction}, {24'h0, exp_dir[2]});
  endtask

  // hang guard, well above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    exp_dir = '{DIR_RST, DIR_RST, DIR_RST};
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk("acc_rst", OFF_ACC, {24'h0, ACC_RST}, RESP_OKAY);
    rd_chk("stat_rst", OFF_STAT, 32'h0, RESP_OKAY);
    rd_chk("dira_rst", OFF_DIR_A, {24'h0, DIR_RST}, RESP_OKAY);
    wr(12'h018, 32'h55, RESP_SLVERR);
    rd_chk("unmapped", 12'h018, 32'h0, RESP_SLVERR);
    wr(OFF_DIR_B, 32'h12, RESP_OKAY);
    rd_chk("dirb_ro", OFF_DIR_B, {24'h0, DIR_RST}, RESP_OKAY);
    run_op(OP_SUB_FILE, 1'h0, 8'h00, 8'h05, 8'h03, 1'h0);
    run_op(OP_SUB_FILE, 1'h1, 8'h00, 8'h3A, 8'h3A, 1'h0);
    run_op(OP_SUB_BORROW, 1'h0, 8'h00, 8'h10, 8'h30, 1'h0);
    run_op(OP_SUB_BORROW, 1'h1, 8'h00, 8'h10, 8'h30, 1'h1);
    run_op(OP_SUB_BORROW, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
    run_op(OP_SUB_LIT, 1'h1, 8'hFF, 8'h01, 8'h77, 1'h0);
    run_op(OP_SUB_LIT, 1'h0, 8'h00, 8'h00, 8'h77, 1'h1);
    run_op(OP_SWAP, 1'h0, 8'h00, 8'h99, 8'hA5, 1'h1);
    run_op(OP_SWAP, 1'h1, 8'h00, 8'h99, 8'h1E, 1'h0);
    run_op(OP_XOR_LIT, 1'h1, 8'h5A, 8'h5A, 8'h00, 1'h0);
    run_op(OP_XOR_FILE, 1'h0, 8'h00, 8'h0F, 8'hF0, 1'h1);
    run_op(OP_XOR_FILE, 1'h1, 8'h00, 8'h33, 8'h33, 1'h0);
    run_dir(7'h05, 8'h3C);
    run_dir(7'h06, 8'h00);
    run_dir(7'h07, 8'hA5);
    // unused opcode raises err and leaves the flags alone
    wr(OFF_CMD, 32'h7, RESP_OKAY);
    rd_chk("op7_stat", OFF_STAT, 32'hD, RESP_OKAY);
    run_dir(7'h04, 8'h11);
    run_dir(7'h08, 8'h22);
    rd_chk("dirc_rd", OFF_DIR_C, 32'hA5, RESP_OKAY);
    rd_chk("cmd_rd", OFF_CMD, 32'h804, RESP_OKAY);
    summarize();
  end
endmodule

bind sswx_core sswx_core_sva i_sswx_core_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .port_a_direction, .port_b_direction, .port_c_direction);
